// File: rtl/btce_regs.svh
// register offsets, field positions, reset values and cycle counts of the executor
// Overview of operation
// - flag-to-bit write puts C or Z into source bit chosen by base, no flags.
// - test-and-skip ops take one cycle, two or three when skipping, no flags.
// - single bit probe picks bit by literal or base, reports into C or Z only.
// - probe-then-set captures the bit into C or its complement into Z, then sets it, one cycle.
// - call takes four cycles; literal form two words, indirect one; updates STACK_FRAME_ACTIVE_FLAG.
// - watchdog restart op restarts the timer in one cycle, touching WATCHDOG_EXPIRED_FLAG and sleep.
// - compare forms base minus operand, drops difference, sets C DC N OV Z.
// - compare-with-zero subtracts zero from file or source, sets five flags.
// - compare-with-borrow forms base minus operand minus borrow, sets five flags.
// - compare-and-skip skips on equal, greater, less, unequal; no flag change.
// - compare-and-branch one word, one cycle untaken, five taken, flags untouched.
// - access to a non-core special register costs one extra cycle.
`ifndef BTCE_REGS_SVH
`define BTCE_REGS_SVH

`define BTCE_ADDR_W        8
`define BTCE_OFS_CTRL      8'h00
`define BTCE_OFS_STATUS    8'h04
`define BTCE_OFS_CYCLES    8'h08
`define BTCE_OFS_COUNT     8'h0C
`define BTCE_OFS_LAST_OP   8'h10

`define BTCE_CTRL_CNT_EN   0
`define BTCE_CTRL_CNT_CLR  1
`define BTCE_CTRL_RST      1'b1
`define BTCE_STATUS_RST    8'h00
`define BTCE_STATUS_MSB    7

`define BTCE_CYC_ONE       4'h1
`define BTCE_CYC_CALL      4'h4
`define BTCE_CYC_BRANCH    4'h5
`define BTCE_CYC_SKIP1     4'h2
`define BTCE_CYC_SKIP2     4'h3
`define BTCE_CYC_SFR       4'h1
`define BTCE_WORDS_ONE     2'h1
`define BTCE_WORDS_TWO     2'h2

`endif

// File: rtl/btce_pkg.sv
// types shared by the bit-test / compare executor
package btce_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_FLAG_TO_BIT_WRITE, OP_TEST_SKIP_IF_ZERO, OP_TEST_SKIP_IF_ONE,
    OP_SINGLE_BIT_PROBE, OP_PROBE_THEN_SET, OP_CALL, OP_WATCHDOG_RESTART,
    OP_COMPARE, OP_COMPARE_ZERO, OP_COMPARE_WITH_BORROW,
    OP_SKIP_WHEN_EQUAL, OP_SKIP_WHEN_GREATER, OP_SKIP_WHEN_LESS, OP_SKIP_WHEN_UNEQUAL,
    OP_BRANCH_WHEN_EQUAL, OP_BRANCH_WHEN_GREATER, OP_BRANCH_WHEN_LESS,
    OP_BRANCH_WHEN_UNEQUAL
  } btce_op_t;

  typedef enum logic [1:0] {SRC_FILE, SRC_REG, SRC_LIT} btce_src_t;
  typedef enum logic [1:0] {CALL_LIT, CALL_IND, CALL_LONG} btce_call_t;

  typedef struct packed {
    btce_op_t    op;
    btce_src_t   src_sel;
    logic        use_base_idx;
    logic        to_carry;
    btce_call_t  call_kind;
    logic [3:0]  bit4;
    logic [7:0]  lit8;
    logic [22:0] lit23;
    logic [22:0] branch_target;
    logic [15:0] base_val;
    logic [15:0] src_val;
    logic [15:0] file_val;
    logic [15:0] working_default_reg_val;
    logic        non_core_sfr;
    logic        next_is_two_word;
  } btce_instr_t;

  typedef struct packed {
    logic sleep;
    logic watchdog_expired_flag;
    logic stack_frame_active_flag;
    logic signed_wrap_flag;
    logic n;
    logic digit_carry_flag;
    logic z;
    logic c;
  } btce_flags_t;

  typedef struct packed {
    logic        wb_en;
    logic        wb_file;
    logic [15:0] wb_data;
    logic        skip;
    logic [1:0]  skip_words;
    logic        redirect;
    logic        call;
    logic [22:0] target;
    logic [1:0]  words;
    logic        wdt_restart;
  } btce_result_t;

  typedef enum logic {SEQ_IDLE, SEQ_BUSY} btce_seq_state_t;

  typedef struct packed {
    btce_seq_state_t state;
    logic [3:0]      cnt;
    logic            ready;
  } btce_seq_t;

  typedef struct packed {
    logic         cnt_en;
    btce_flags_t  status;
    logic [3:0]   last_cycles;
    btce_op_t     last_op;
    logic [31:0]  exec_count;
    logic         ahb_wr;
    logic [7:0]   ahb_addr;
    logic [31:0]  hrdata;
    logic         hready;
    logic         hresp;
    logic         res_valid;
    btce_result_t res;
  } btce_state_t;
endpackage

// File: rtl/btce_alu.sv
// subtractor producing compare flags
`timescale 1ns/100ps
`default_nettype none
module btce_alu #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  output var  logic [W-1:0] diff,
  output var  logic         c,
  output var  logic         dc,
  output var  logic         n,
  output var  logic         ov,
  output var  logic         z
);
  logic [W:0] sum;
  logic [4:0] nib;

  // a - b - !cin as a + ~b + cin; carry out means no borrow
  assign sum  = {1'b0, a} + {1'b0, ~b} + {{W{1'b0}}, cin};
  assign nib  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
  assign diff = sum[W-1:0];
  assign c    = sum[W];
  assign dc   = nib[4];
  assign n    = diff[W-1];
  assign ov   = (a[W-1] ^ b[W-1]) & (a[W-1] ^ diff[W-1]);
  assign z    = (diff == '0);
endmodule
`default_nettype wire

// File: rtl/btce_seq.sv
// stall sequencer holding the issue port for multi-cycle operations
`timescale 1ns/100ps
`default_nettype none
`include "btce_regs.svh"
module btce_seq (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [3:0] total,
  output var  logic       ready
);
  btce_pkg::btce_seq_t q;
  btce_pkg::btce_seq_t d;

  always_comb begin
    d = q;
    unique case (q.state)
      btce_pkg::SEQ_IDLE: begin
        if (start && (total > `BTCE_CYC_ONE)) begin
          d.state = btce_pkg::SEQ_BUSY;
          d.cnt   = total - `BTCE_CYC_ONE;
          d.ready = 1'b0;
        end
      end
      btce_pkg::SEQ_BUSY: begin
        // issue port reopens once every extra cycle has been spent
        if (q.cnt == `BTCE_CYC_ONE) begin
          d.state = btce_pkg::SEQ_IDLE;
          d.ready = 1'b1;
        end
        d.cnt = q.cnt - `BTCE_CYC_ONE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '{state: btce_pkg::SEQ_IDLE, cnt: 4'h0, ready: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign ready = q.ready;
endmodule
`default_nettype wire

// File: rtl/btce_top.sv
// bit-test, call, watchdog-restart and compare executor with AHB-Lite status port
`timescale 1ns/100ps
`default_nettype none
`include "btce_regs.svh"
module btce_top (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output var  logic                 hreadyout,
  output var  logic                 hresp,
  output var  logic [31:0]          hrdata,
  input  wire logic                 issue_valid,
  input  wire btce_pkg::btce_instr_t issue,
  output var  logic                 issue_ready,
  input  wire logic                 wdt_expire_set,
  input  wire logic                 sleep_set,
  output var  logic                 res_valid,
  output var  btce_pkg::btce_result_t res,
  output var  btce_pkg::btce_flags_t flags
);
  btce_pkg::btce_state_t q;
  btce_pkg::btce_state_t d;

  logic        take;
  logic        seq_ready;
  logic [3:0]  total;
  logic        is_zero_cmp;
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic        cmp_cin;
  logic        f_c;
  logic        f_dc;
  logic        f_n;
  logic        f_ov;
  logic        f_z;
  logic [15:0] bit_opnd;
  logic [3:0]  bit_idx;
  logic        bit_val;
  logic        op_eq;
  logic        op_gt;
  logic        op_lt;
  logic        acc;

  // writes one bit of a word, leaving the others alone
  function automatic logic [15:0] put_bit(input logic [15:0] v, input logic [3:0] i,
                                          input logic b);
    logic [15:0] m;
    m = 16'(16'h0001 << i);
    put_bit = b ? (v | m) : (v & ~m);
  endfunction

  // register read view; taken from the post-write copy so a read right after a write sees it
  function automatic logic [31:0] reg_read(input btce_pkg::btce_state_t s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = 32'h00000000;
    unique case (a)
      `BTCE_OFS_CTRL:    r[`BTCE_CTRL_CNT_EN] = s.cnt_en;
      `BTCE_OFS_STATUS:  r[`BTCE_STATUS_MSB:0] = s.status;
      `BTCE_OFS_CYCLES:  r[3:0] = s.last_cycles;
      `BTCE_OFS_COUNT:   r = s.exec_count;
      `BTCE_OFS_LAST_OP: r[4:0] = s.last_op;
      default:           r = 32'h00000000;
    endcase
    reg_read = r;
  endfunction

  assign take        = issue_valid & seq_ready;
  assign is_zero_cmp = (issue.op == btce_pkg::OP_COMPARE_ZERO);
  // file form compares f with the working default register, or with zero for compare-with-zero
  assign cmp_a = (issue.src_sel == btce_pkg::SRC_FILE) ? issue.file_val :
                 (is_zero_cmp ? issue.src_val : issue.base_val);
  assign cmp_b = is_zero_cmp ? 16'h0000 :
                 (issue.src_sel == btce_pkg::SRC_FILE) ? issue.working_default_reg_val :
                 (issue.src_sel == btce_pkg::SRC_LIT) ? {8'h00, issue.lit8} :
                 issue.src_val;
  // borrow term is the inverted carry
  assign cmp_cin = (issue.op == btce_pkg::OP_COMPARE_WITH_BORROW) ? q.status.c : 1'b1;

  assign bit_opnd = (issue.src_sel == btce_pkg::SRC_FILE) ? issue.file_val : issue.src_val;
  assign bit_idx  = issue.use_base_idx ? issue.base_val[3:0] : issue.bit4;
  assign bit_val  = bit_opnd[bit_idx];

  // skip and branch compares are signed
  assign op_eq = (issue.base_val == issue.src_val);
  assign op_gt = ($signed(issue.base_val) > $signed(issue.src_val));
  assign op_lt = ($signed(issue.base_val) < $signed(issue.src_val));

  assign acc = hsel & htrans[1] & hready;

  btce_alu #(
    .W (16)
  ) u_alu (
    .a    (cmp_a),
    .b    (cmp_b),
    .cin  (cmp_cin),
    .diff (),
    .c    (f_c),
    .dc   (f_dc),
    .n    (f_n),
    .ov   (f_ov),
    .z    (f_z)
  );

  btce_seq u_seq (
    .clk   (clk),
    .rstn  (rstn),
    .start (take),
    .total (total),
    .ready (seq_ready)
  );

  always_comb begin
    d = q;
    total = `BTCE_CYC_ONE;
    d.res_valid = 1'b0;
    d.res = '0;
    d.res.words = `BTCE_WORDS_ONE;
    d.hready = 1'b1;
    d.hresp = 1'b0;

    // software writes land first; hardware updates below override them
    if (q.ahb_wr) begin
      unique case (q.ahb_addr)
        `BTCE_OFS_CTRL: begin
          d.cnt_en = hwdata[`BTCE_CTRL_CNT_EN];
          if (hwdata[`BTCE_CTRL_CNT_CLR]) begin
            d.exec_count = 32'h00000000;
          end
        end
        `BTCE_OFS_STATUS: d.status = btce_pkg::btce_flags_t'(hwdata[`BTCE_STATUS_MSB:0]);
        default: ;
      endcase
    end

    if (take) begin
      d.res_valid = 1'b1;
      d.res.wb_file = (issue.src_sel == btce_pkg::SRC_FILE);
      unique case (issue.op)
        btce_pkg::OP_FLAG_TO_BIT_WRITE: begin
          d.res.wb_en = 1'b1;
          d.res.wb_data = put_bit(bit_opnd, issue.base_val[3:0],
                                  issue.to_carry ? q.status.c : q.status.z);
        end
        btce_pkg::OP_TEST_SKIP_IF_ZERO: d.res.skip = ~bit_val;
        btce_pkg::OP_TEST_SKIP_IF_ONE:  d.res.skip = bit_val;
        btce_pkg::OP_SINGLE_BIT_PROBE: begin
          if (issue.to_carry) begin
            d.status.c = bit_val;
          end else begin
            d.status.z = ~bit_val;
          end
        end
        btce_pkg::OP_PROBE_THEN_SET: begin
          if (issue.to_carry) begin
            d.status.c = bit_val;
          end else begin
            d.status.z = ~bit_val;
          end
          d.res.wb_en = 1'b1;
          d.res.wb_data = put_bit(bit_opnd, bit_idx, 1'b1);
        end
        btce_pkg::OP_CALL: begin
          total = `BTCE_CYC_CALL;
          d.res.redirect = 1'b1;
          d.res.call = 1'b1;
          d.status.stack_frame_active_flag = 1'b0;
          unique case (issue.call_kind)
            btce_pkg::CALL_LIT: begin
              d.res.target = issue.lit23;
              d.res.words = `BTCE_WORDS_TWO;
            end
            btce_pkg::CALL_LONG: d.res.target = {issue.base_val[6:0], issue.src_val};
            default:             d.res.target = {7'h00, issue.src_val};
          endcase
        end
        btce_pkg::OP_WATCHDOG_RESTART: begin
          d.res.wdt_restart = 1'b1;
          d.status.watchdog_expired_flag = 1'b0;
          d.status.sleep = 1'b0;
        end
        btce_pkg::OP_COMPARE, btce_pkg::OP_COMPARE_ZERO,
        btce_pkg::OP_COMPARE_WITH_BORROW: begin
          // difference is dropped; only the flags survive
          d.status.c = f_c;
          d.status.digit_carry_flag = f_dc;
          d.status.n = f_n;
          d.status.signed_wrap_flag = f_ov;
          d.status.z = f_z;
        end
        btce_pkg::OP_SKIP_WHEN_EQUAL:   d.res.skip = op_eq;
        btce_pkg::OP_SKIP_WHEN_GREATER: d.res.skip = op_gt;
        btce_pkg::OP_SKIP_WHEN_LESS:    d.res.skip = op_lt;
        btce_pkg::OP_SKIP_WHEN_UNEQUAL: d.res.skip = ~op_eq;
        btce_pkg::OP_BRANCH_WHEN_EQUAL:   d.res.redirect = op_eq;
        btce_pkg::OP_BRANCH_WHEN_GREATER: d.res.redirect = op_gt;
        btce_pkg::OP_BRANCH_WHEN_LESS:    d.res.redirect = op_lt;
        btce_pkg::OP_BRANCH_WHEN_UNEQUAL: d.res.redirect = ~op_eq;
        default: ;
      endcase

      if (d.res.redirect && !d.res.call) begin
        d.res.target = issue.branch_target;
        total = `BTCE_CYC_BRANCH;
      end
      // a two-word follower must have both words thrown away
      if (d.res.skip) begin
        d.res.skip_words = issue.next_is_two_word ? `BTCE_WORDS_TWO : `BTCE_WORDS_ONE;
        total = issue.next_is_two_word ? `BTCE_CYC_SKIP2 : `BTCE_CYC_SKIP1;
      end
      if (issue.non_core_sfr) begin
        total = total + `BTCE_CYC_SFR;
      end
      d.last_cycles = total;
      d.last_op = issue.op;
      if (d.cnt_en) begin
        d.exec_count = q.exec_count + 32'h00000001;
      end
    end

    // outside events win over a clear in the same cycle
    if (wdt_expire_set) begin
      d.status.watchdog_expired_flag = 1'b1;
    end
    if (sleep_set) begin
      d.status.sleep = 1'b1;
    end

    d.ahb_wr = acc & hwrite;
    d.ahb_addr = haddr[7:0];
    if (acc && !hwrite) begin
      d.hrdata = reg_read(d, haddr[7:0]);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.cnt_en <= `BTCE_CTRL_RST;
      q.status <= btce_pkg::btce_flags_t'(`BTCE_STATUS_RST);
      q.hready <= 1'b1;
      q.res.words <= `BTCE_WORDS_ONE;
    end else begin
      q <= d;
    end
  end

  assign hreadyout   = q.hready;
  assign hresp       = q.hresp;
  assign hrdata      = q.hrdata;
  assign issue_ready = seq_ready;
  assign res_valid   = q.res_valid;
  assign res         = q.res;
  assign flags       = q.status;
endmodule
`default_nettype wire

// File: tb/btce_top_sva.sv
// assertions on the executor's issue, result and flag ports
`timescale 1ns/100ps
`default_nettype none
module btce_top_chk (
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic                   issue_valid,
  input wire btce_pkg::btce_instr_t  issue,
  input wire logic                   issue_ready,
  input wire logic                   wdt_expire_set,
  input wire logic                   sleep_set,
  input wire btce_pkg::btce_result_t res,
  input wire btce_pkg::btce_flags_t  flags
);
  logic               go;
  logic               one;
  btce_pkg::btce_op_t o;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // hardware flag inputs win over op updates, so they are kept out
  assign go = issue_valid && issue_ready && !issue.non_core_sfr && !wdt_expire_set && !sleep_set;
  assign o = issue.op;
  assign one = o inside {btce_pkg::OP_SINGLE_BIT_PROBE, btce_pkg::OP_PROBE_THEN_SET} ||
    (o >= btce_pkg::OP_WATCHDOG_RESTART && o <= btce_pkg::OP_COMPARE_WITH_BORROW);
  sequence s_two;
    !issue_ready [*2] ##1 issue_ready;
  endsequence
  sequence s_three;
    !issue_ready [*3] ##1 issue_ready;
  endsequence
  sequence s_four;
    !issue_ready [*4] ##1 issue_ready;
  endsequence
  AST_ONE_CYCLE: assert property (go && one |=> issue_ready)
    else $error("single cycle op stalled");
  AST_SFR_EXTRA: assert property (
    issue_valid && issue_ready && issue.non_core_sfr && o == btce_pkg::OP_COMPARE
    |=> !issue_ready ##1 issue_ready) else $error("special register op not two cycles");
  AST_CALL: assert property (
    go && o == btce_pkg::OP_CALL |=> res.call && !flags.stack_frame_active_flag ##0 s_three)
    else $error("call length or frame flag wrong");
  AST_BRANCH: assert property (
    go && o == btce_pkg::OP_BRANCH_WHEN_EQUAL && issue.base_val == issue.src_val
    |=> res.redirect && res.target == $past(issue.branch_target) ##0 s_four)
    else $error("taken branch wrong");
  AST_SKIP_TWO: assert property (
    go && o == btce_pkg::OP_SKIP_WHEN_EQUAL && issue.base_val == issue.src_val &&
    issue.next_is_two_word |=> res.skip && res.skip_words == 2'h2 ##0 s_two)
    else $error("two word skip wrong");
  AST_NO_FLAGS: assert property (
    go && (o inside {btce_pkg::OP_FLAG_TO_BIT_WRITE, btce_pkg::OP_TEST_SKIP_IF_ZERO,
    btce_pkg::OP_TEST_SKIP_IF_ONE} || o >= btce_pkg::OP_SKIP_WHEN_EQUAL) |=> $stable(flags))
    else $error("flags changed");
  AST_WDT: assert property (
    go && o == btce_pkg::OP_WATCHDOG_RESTART
    |=> res.wdt_restart && !flags.watchdog_expired_flag && !flags.sleep)
    else $error("watchdog restart wrong");
  AST_CMP_ZERO: assert property (
    go && o == btce_pkg::OP_COMPARE_ZERO && issue.src_sel == btce_pkg::SRC_REG
    |=> flags.z == ($past(issue.src_val) == 16'h0000) && flags.c)
    else $error("compare with zero flags wrong");
endmodule
bind btce_top btce_top_chk i_chk (.clk(clk), .rstn(rstn), .issue_valid(issue_valid),
  .issue(issue), .issue_ready(issue_ready), .wdt_expire_set(wdt_expire_set),
  .sleep_set(sleep_set), .res(res), .flags(flags));
`default_nettype wire

// File: tb/btce_fetch_model.sv
// fetch-side partner: offers one operation, optionally after a delay
`timescale 1ns/100ps
`default_nettype none
module btce_fetch_model (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  req,
  input  wire btce_pkg::btce_instr_t instr,
  input  wire logic [3:0]            gap,
  input  wire logic                  issue_ready,
  output var  logic                  issue_valid,
  output var  btce_pkg::btce_instr_t issue
);
  logic       pend_q;
  logic [3:0] wait_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      issue_valid <= 1'b0;
      issue <= '0;
      pend_q <= 1'b0;
      wait_q <= 4'h0;
    end else if (issue_valid) begin
      issue_valid <= !issue_ready;
    end else if (pend_q && wait_q == 4'h0) begin
      issue_valid <= 1'b1;
      issue <= instr;
      pend_q <= 1'b0;
    end else begin
      // idle lines wander so a stale op never looks live
      issue <= btce_pkg::btce_instr_t'(~issue);
      pend_q <= pend_q || req;
      wait_q <= req ? gap : wait_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the bit-test, call and compare executor
`timescale 1ns/100ps
`default_nettype none
`include "btce_regs.svh"
module tb_top;
  logic                   clk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   hsel = 1'b0;
  logic [31:0]            haddr = 32'h0;
  logic [1:0]             htrans = 2'h0;
  logic                   hwrite = 1'b0;
  logic [31:0]            hwdata = 32'h0;
  logic                   hreadyout;
  logic [31:0]            hrdata;
  logic                   hresp;
  logic                   issue_valid;
  btce_pkg::btce_instr_t  issue;
  logic                   issue_ready;
  logic                   wdt_set = 1'b0;
  logic                   slp_set = 1'b0;
  logic                   res_valid;
  btce_pkg::btce_result_t res;
  btce_pkg::btce_flags_t  flags;
  logic                   req = 1'b0;
  logic [3:0]             gap = 4'h0;
  btce_pkg::btce_instr_t  instr = '0;
  btce_pkg::btce_instr_t  x;
  btce_pkg::btce_result_t rq;
  logic [31:0]            rd;
  int                     miscompares = 0;
  int                     cmp_count = 0;
  always #20 clk = ~clk;
  btce_top i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .issue_valid(issue_valid),
    .issue(issue), .issue_ready(issue_ready), .wdt_expire_set(wdt_set), .sleep_set(slp_set),
    .res_valid(res_valid), .res(res), .flags(flags));
  btce_fetch_model i_fetch (.clk(clk), .rstn(rstn), .req(req), .instr(instr), .gap(gap),
    .issue_ready(issue_ready), .issue_valid(issue_valid), .issue(issue));
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h", $time, m, g);
    end
  endtask
  task automatic hwait();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= wr;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    rd = hrdata;
    chk(32'(hresp), 32'h0, "hresp");
  endtask
  function automatic btce_pkg::btce_instr_t mk(btce_pkg::btce_op_t o, logic [15:0] b, s);
    btce_pkg::btce_instr_t i;
    i = '0;
    i.op = o;
    i.base_val = b;
    i.src_val = s;
    i.src_sel = btce_pkg::SRC_REG;
    return i;
  endfunction
  task automatic op(input btce_pkg::btce_instr_t i, input logic [3:0] cyc, g);
    int n;
    @(posedge clk);
    instr <= i;
    gap <= g;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (res_valid !== 1'b1 && n < 30);
    if (res_valid !== 1'b1) begin
      miscompares++;
      conclude();
    end
    rq = res;
    n = 1;
    while (issue_ready !== 1'b1 && n < 9) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n), 32'(cyc), "cycles");
  endtask
  task automatic t_bits();
    ahb(1'b1, `BTCE_OFS_STATUS, 32'h1);
    x = mk(btce_pkg::OP_FLAG_TO_BIT_WRITE, 16'h5, 16'h0);
    x.to_carry = 1'b1;
    x.use_base_idx = 1'b1;
    op(x, 4'h1, 4'h0);
    chk(32'(rq.wb_data), 32'h20, "bit write");
    ahb(1'b1, `BTCE_OFS_STATUS, 32'h2);
    x = mk(btce_pkg::OP_SINGLE_BIT_PROBE, 16'h0, 16'h8);
    x.bit4 = 4'h3;
    x.to_carry = 1'b1;
    op(x, 4'h1, 4'h0);
    chk(32'(flags), 32'h3, "probe c");
    x.to_carry = 1'b0;
    op(x, 4'h1, 4'h0);
    chk(32'(flags), 32'h1, "probe z");
    x = mk(btce_pkg::OP_PROBE_THEN_SET, 16'h0, 16'h0);
    x.bit4 = 4'h2;
    x.to_carry = 1'b1;
    op(x, 4'h1, 4'h0);
    chk({24'h0, flags}, 32'h0, "probe-set flag");
    chk(32'(rq.wb_data), 32'h4, "probe-set data");
  endtask
  function automatic logic [15:0] pick(int k);
    return (k == 1) ? 16'h7 : (k == 0) ? 16'h5 : 16'h3;
  endfunction
  task automatic t_skip();
    x = mk(btce_pkg::OP_TEST_SKIP_IF_ZERO, 16'h0, 16'h0);
    x.next_is_two_word = 1'b1;
    op(x, 4'h3, 4'h0);
    x.op = btce_pkg::OP_TEST_SKIP_IF_ONE;
    op(x, 4'h1, 4'h0);
    x = mk(btce_pkg::OP_SKIP_WHEN_EQUAL, 16'h9, 16'h9);
    x.next_is_two_word = 1'b1;
    op(x, 4'h3, 4'h0);
    chk(32'(rq.skip_words), 32'h2, "skip two");
    for (int k = 0; k < 4; k++) begin
      op(mk(btce_pkg::btce_op_t'(k + 11), pick(k), 16'h5), 4'h2, 4'h0);
      chk(32'(rq.skip_words), 32'h1, "skip");
      x = mk(btce_pkg::btce_op_t'(k + 15), pick(k), 16'h5);
      x.branch_target = 23'h123;
      op(x, 4'h5, 4'h0);
      chk(32'(rq.target), 32'h123, "branch");
    end
    op(mk(btce_pkg::OP_SKIP_WHEN_GREATER, 16'hFFFF, 16'h1), 4'h1, 4'h0);
    op(mk(btce_pkg::OP_BRANCH_WHEN_EQUAL, 16'h3, 16'h5), 4'h1, 4'h0);
  endtask
  task automatic t_call();
    ahb(1'b1, `BTCE_OFS_STATUS, 32'h20);
    x = mk(btce_pkg::OP_CALL, 16'h0, 16'hABC);
    x.lit23 = 23'h12345;
    op(x, 4'h4, 4'h0);
    chk(32'({rq.words, rq.target}), 32'h1012345, "call");
    chk({24'h0, flags}, 32'h0, "frame flag");
    x.call_kind = btce_pkg::CALL_IND;
    op(x, 4'h4, 4'h3);
    chk(32'({rq.words, rq.target}), 32'h800ABC, "call ind");
    ahb(1'b0, `BTCE_OFS_CYCLES, 32'h0);
    chk(rd, 32'h4, "cycles reg");
    ahb(1'b0, `BTCE_OFS_LAST_OP, 32'h0);
    chk(rd, 32'(btce_pkg::OP_CALL), "last op");
    ahb(1'b1, `BTCE_OFS_CTRL, 32'h3);
    ahb(1'b0, `BTCE_OFS_COUNT, 32'h0);
    chk(rd, 32'h0, "count clear");
  endtask
  task automatic cmpf(input btce_pkg::btce_op_t o, input logic [15:0] b, s, input logic [7:0] f);
    op(mk(o, b, s), 4'h1, 4'h0);
    chk({24'h0, flags}, 32'(f), "cmp flags");
  endtask
  task automatic t_cmp();
    ahb(1'b1, `BTCE_OFS_STATUS, 32'h0);
    cmpf(btce_pkg::OP_COMPARE, 16'h10, 16'h11, 8'h08);
    cmpf(btce_pkg::OP_COMPARE_WITH_BORROW, 16'h5, 16'h5, 8'h08);
    cmpf(btce_pkg::OP_COMPARE, 16'h8000, 16'h1, 8'h11);
    cmpf(btce_pkg::OP_COMPARE_WITH_BORROW, 16'h5, 16'h5, 8'h07);
    cmpf(btce_pkg::OP_COMPARE_ZERO, 16'h0, 16'h8000, 8'h0D);
    x = mk(btce_pkg::OP_COMPARE, 16'h5, 16'h0);
    x.src_sel = btce_pkg::SRC_LIT;
    x.lit8 = 8'h5;
    x.non_core_sfr = 1'b1;
    op(x, 4'h2, 4'h0);
    chk({24'h0, flags}, 32'h07, "lit");
  endtask
  task automatic t_wdt();
    @(posedge clk);
    wdt_set <= 1'b1;
    slp_set <= 1'b1;
    @(posedge clk);
    wdt_set <= 1'b0;
    slp_set <= 1'b0;
    @(negedge clk);
    chk({24'h0, flags}, 32'hC7, "hw flag set");
    op(mk(btce_pkg::OP_WATCHDOG_RESTART, 16'h0, 16'h0), 4'h1, 4'h0);
    chk({23'h0, rq.wdt_restart, flags}, 32'h107, "wdt");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    ahb(1'b0, `BTCE_OFS_CTRL, 32'h0);
    chk(rd, 32'h1, "ctrl");
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0, "unmapped");
    t_bits();
    t_skip();
    t_call();
    t_cmp();
    t_wdt();
    // six compares and one restart since the clear
    ahb(1'b0, `BTCE_OFS_COUNT, 32'h0);
    chk(rd, 32'h7, "count");
    conclude();
  end
endmodule
`default_nettype wire
